//--- core/ddr_io_pkg.sv
// Shared constants for the DDR I/O read and write datapath
package ddr_io_pkg;

   // Data lanes in one strobe group
   localparam int DQ_W_DEF        = 8;
   // Width of the strobe delay control code
   localparam int CODE_W          = 6;
   // Reset value of the delay codes (no delay until calibrated)
   localparam logic [CODE_W-1:0] CODE_RST = 6'h00;
   // Polarity values: core clock used true or inverted
   localparam logic POL_TRUE      = 1'b0;
   localparam logic POL_INVERT    = 1'b1;
   // Output enable level while idle (active low, so set = released)
   localparam logic OE_N_RELEASED = 1'b1;
   // Depth of the two-flop synchronisers
   localparam int SYNC_STAGES     = 2;

   // Placement of a strobe group around the die
   typedef enum logic [1:0] {
      SIDE_LEFT   = 2'b00,
      SIDE_RIGHT  = 2'b01,
      SIDE_TOP    = 2'b10,
      SIDE_BOTTOM = 2'b11
   } group_side_t;

   // Polarity detector states
   typedef enum logic [1:0] {
      DET_IDLE   = 2'b00,
      DET_ARMED  = 2'b01,
      DET_LOCKED = 2'b10
   } det_state_t;

endpackage

//--- core/ddr_io_path.sv
// DDR I/O read capture, core transfer and write serialisation datapath
//
// Summary of operation
// RL1: Core raises read window with read command.
// RL2: Read window may overlap previous burst tail.
// RL3: Core drops read window inside strobe preamble.
// RL4: Core times preamble from latency plus round trip.
// RL5: Half mode captures rise and fall words.
// RL6: Polarity picks true or inverted core clock.
// RL7: Half mode data enters on selected edge.
// RL8: Full mode adds stage on fixed edge.
// RL9: Full mode slow clocks come from core clock.
// RL10: Full mode stage shares output register flops.
// RL11: Output block drives data, strobe, enables.
// RL12: Fall and rise words serialise onto pin.
// RL13: Core holds output reset low while writing.
// RL14: No clock enable; tristate reset sets release.
// RL15: Output reset clears flops, latch keeps contents.
// RL16: Transfer clock inverted inside output block.
// RL17: Delay element takes six-bit code, ninety degrees.
// RL18: Left and right calibrators feed their halves.
// RL19: Delayed strobe clocks first capture stage.
// RL20: Detector finds first strobe rise after preamble.
// RL21: Memory parks strobe, drives low in preamble.
// RL22: Data valid flags read data entering core.
// RL23: Polarity 0 if clock low, else 1.
// RL24: Data valid holds until next read window.
// RL25: Delay update only outside read data reception.
// RL26: Input clock enable low holds capture registers.
// RL27: Input reset clears both capture outputs.
`timescale 1ns/100ps

module ddr_io_path
   import ddr_io_pkg::*;
#(
   parameter int          DQ_W          = DQ_W_DEF,
   parameter bit          FULL_CYCLE    = 1'b0,
   parameter group_side_t GROUP_SIDE    = SIDE_LEFT,
   parameter bit          TOP_FROM_LEFT = 1'b1
) (
   // Core clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // Memory side read pins; strobe is the link clock
   input  wire logic              strobe_i,
   input  wire logic              preamble_detect_i,
   input  wire logic [DQ_W-1:0]   dq_i,
   // Core read control
   input  wire logic              read_window_i,
   input  wire logic              in_ce_i,
   input  wire logic              in_rst_i,
   // Delay calibration
   input  wire logic              delay_update_request_n_i,
   input  wire logic [CODE_W-1:0] cal_code_left_i,
   input  wire logic [CODE_W-1:0] cal_code_right_i,
   // Core write data
   input  wire logic [DQ_W-1:0]   fall_edge_word_i,
   input  wire logic [DQ_W-1:0]   rise_edge_word_i,
   input  wire logic              strobe_fall_i,
   input  wire logic              strobe_rise_i,
   input  wire logic              write_drive_i,
   input  wire logic              local_set_reset_i,
   // Read results to core
   output logic [DQ_W-1:0]        rise_capture_out_o,
   output logic [DQ_W-1:0]        fall_capture_out_o,
   output logic                   read_data_valid_o,
   output logic                   sync_clock_polarity_o,
   output logic [CODE_W-1:0]      strobe_delay_code_o,
   // Memory side write pins
   output logic [DQ_W-1:0]        dq_o,
   output logic [DQ_W-1:0]        dq_oe_n_o,
   output logic                   strobe_o,
   output logic                   strobe_oe_n_o,
   output logic                   write_transfer_clock_o
);

   // Elaboration-time sanity on the lane count
   if (DQ_W < 1 || DQ_W > 64) begin : g_bad_width
      $error("ddr_io_path: DQ_W must be 1 to 64");
   end

   localparam int LANES = DQ_W + 1;  // Data lanes plus the strobe lane

   // ---------------- Delay calibration ----------------

   logic [CODE_W-1:0] code_left_ff;
   logic [CODE_W-1:0] code_right_ff;
   logic [CODE_W-1:0] nxt_group_code;

   // Codes follow the loops only while update is held low; core must
   // keep it high while read data is arriving [RL25]
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         code_left_ff  <= CODE_RST;
         code_right_ff <= CODE_RST;
      end else if (!delay_update_request_n_i) begin
         code_left_ff  <= cal_code_left_i;   // [RL18]
         code_right_ff <= cal_code_right_i;  // [RL18]
      end
   end

   // Each loop feeds its own side and one of the top and bottom halves
   always_comb begin
      case (GROUP_SIDE)
         SIDE_LEFT:   nxt_group_code = code_left_ff;   // [RL18]
         SIDE_RIGHT:  nxt_group_code = code_right_ff;  // [RL18]
         SIDE_TOP:    nxt_group_code = TOP_FROM_LEFT ?
                                       code_left_ff : code_right_ff;
         SIDE_BOTTOM: nxt_group_code = TOP_FROM_LEFT ?
                                       code_right_ff : code_left_ff;
         default:     nxt_group_code = code_left_ff;
      endcase
   end

   // The analog line applies this code for a quarter-period delay;
   // strobe_i is taken here as already delayed by that line [RL17]
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         strobe_delay_code_o <= CODE_RST;
      end else begin
         strobe_delay_code_o <= nxt_group_code;  // [RL17]
      end
   end

   // ---------------- Strobe domain capture ----------------

   logic            cap_rst;
   logic [DQ_W-1:0] cap_rise_ff;   // Rise data, strobe rising edge
   logic [DQ_W-1:0] cap_fall_ff;   // Fall data, strobe falling edge
   logic [DQ_W-1:0] cap_align_ff;  // Rise data moved to falling edge
   logic            cap_tog_ff;    // Flips on each new word pair

   // Input reset clears capture regardless of strobe activity [RL27]
   assign cap_rst = rst_i | in_rst_i;

   // First stage is clocked by the delayed strobe [RL19] [RL5]
   always_ff @(posedge strobe_i or posedge cap_rst) begin
      if (cap_rst) begin
         cap_rise_ff <= '0;
      end else if (in_ce_i) begin  // Hold when disabled [RL26]
         cap_rise_ff <= dq_i;
      end
   end

   // Fall data and realigned rise data on the falling strobe edge
   always_ff @(negedge strobe_i or posedge cap_rst) begin
      if (cap_rst) begin
         cap_fall_ff  <= '0;
         cap_align_ff <= '0;
         cap_tog_ff   <= 1'b0;
      end else if (in_ce_i) begin  // [RL26]
         cap_fall_ff  <= dq_i;          // [RL5]
         cap_align_ff <= cap_rise_ff;   // [RL5]
         cap_tog_ff   <= ~cap_tog_ff;
      end
   end

   // ---------------- Core side event and preamble sync ----------------

   logic [SYNC_STAGES-1:0] tog_sync_ff;
   logic                   tog_seen_ff;
   logic                   take;
   logic [SYNC_STAGES-1:0] pre_pos_ff;
   logic [SYNC_STAGES-1:0] pre_neg_ff;
   logic                   pre_pos_last_ff;
   logic                   pre_neg_last_ff;  // Fall sampler at pos rise

   // Word pair event crosses by toggle; first flop feeds only the second
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tog_sync_ff <= '0;
         tog_seen_ff <= 1'b0;
      end else begin
         tog_sync_ff <= {tog_sync_ff[0], cap_tog_ff};
         tog_seen_ff <= tog_sync_ff[1];
      end
   end

   assign take = tog_sync_ff[1] ^ tog_seen_ff;

   // Preamble detect sampled on both core edges to learn clock phase
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pre_pos_ff      <= '0;
         pre_pos_last_ff <= 1'b0;
         pre_neg_last_ff <= 1'b0;
      end else begin
         pre_pos_ff      <= {pre_pos_ff[0], preamble_detect_i};
         pre_pos_last_ff <= pre_pos_ff[1];
         pre_neg_last_ff <= pre_neg_ff[1];
      end
   end

   always_ff @(negedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pre_neg_ff <= '0;
      end else begin
         pre_neg_ff <= {pre_neg_ff[0], preamble_detect_i};
      end
   end

   // ---------------- Polarity detector ----------------

   det_state_t det_ff;
   logic       win_last_ff;
   logic       win_rise;
   logic       pre_rise;
   logic       pol_ff;

   assign win_rise = read_window_i & ~win_last_ff;
   assign pre_rise = pre_pos_ff[1] & ~pre_pos_last_ff;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         win_last_ff <= 1'b0;
      end else begin
         win_last_ff <= read_window_i;
      end
   end

   // A new window re-arms the detector and clears valid; capture of the previous
   // burst's tail goes on untouched [RL2]
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         det_ff <= DET_IDLE;
      end else begin
         case (det_ff)
            DET_IDLE:   if (win_rise) det_ff <= DET_ARMED;
            DET_ARMED:  if (pre_rise) det_ff <= DET_LOCKED;  // [RL20]
            DET_LOCKED: if (win_rise) det_ff <= DET_ARMED;
            default:    det_ff <= DET_IDLE;
         endcase
      end
   end

   // If the falling-edge sampler was high on the edge the rising-edge
   // sampler first saw the preamble, the clock was high, so invert
   // [RL23] [RL20]
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pol_ff <= POL_TRUE;
      end else if (det_ff == DET_ARMED && pre_rise) begin
         pol_ff <= pre_neg_last_ff ? POL_INVERT : POL_TRUE;  // [RL23]
      end
   end

   assign sync_clock_polarity_o = pol_ff;

   // ---------------- Synchronisation stage ----------------

   logic            sync_clk;
   logic [DQ_W-1:0] sync_rise_ff;
   logic [DQ_W-1:0] sync_fall_ff;

   // Core clock used true or inverted; polarity changes only between
   // bursts, so the swap lands while no word is pending [RL6]
   assign sync_clk = clk_sys_i ^ pol_ff;

   // Half-cycle hop into the core on the selected edge [RL7]
   always_ff @(posedge sync_clk or posedge cap_rst) begin
      if (cap_rst) begin
         sync_rise_ff <= '0;
         sync_fall_ff <= '0;
      end else if (in_ce_i && take) begin  // [RL26]
         sync_rise_ff <= cap_align_ff;  // [RL7]
         sync_fall_ff <= cap_fall_ff;   // [RL7]
      end
   end

   // ---------------- Shared transfer / output flops ----------------

   logic [LANES-1:0] reg_rise_ff;   // Rise word, or full-mode rise data
   logic [LANES-1:0] reg_fall_ff;   // Fall word, or full-mode fall data
   logic [LANES-1:0] latch_fall_ff; // Output hold stage, never reset
   logic [LANES-1:0] oe_n_ff;
   logic [LANES-1:0] wr_rise;
   logic [LANES-1:0] wr_fall;
   logic [LANES-1:0] lane_q;
   logic             xfer_clk;
   logic             out_rst;

   assign wr_rise = {strobe_rise_i, rise_edge_word_i};
   assign wr_fall = {strobe_fall_i, fall_edge_word_i};

   // Transfer clock is used inverted inside the block, so the hold
   // stage loads half a period after the rise and fall flops [RL16]
   assign xfer_clk               = ~clk_sys_i;
   assign write_transfer_clock_o = clk_sys_i;

   // Full mode resets these flops with the capture path; else the
   // output reset, which the core keeps low while writing [RL13]
   assign out_rst = FULL_CYCLE ? cap_rst : (rst_i | local_set_reset_i);

   for (genvar i = 0; i < LANES; i++) begin : g_lane
      logic nxt_rise;
      logic nxt_fall;

      // In full mode data lanes borrow the output flops, so these
      // lanes cannot write at the same time [RL10]
      if (FULL_CYCLE && i < DQ_W) begin : g_shared
         assign nxt_rise = (in_ce_i) ? sync_rise_ff[i] : reg_rise_ff[i];
         assign nxt_fall = (in_ce_i) ? sync_fall_ff[i] : reg_fall_ff[i];
      end else begin : g_write
         assign nxt_rise = wr_rise[i];  // [RL12]
         assign nxt_fall = wr_fall[i];  // [RL12]
      end

      // Runs every edge, no enable of its own [RL14] [RL8] [RL9]
      always_ff @(posedge clk_sys_i or posedge out_rst) begin
         if (out_rst) begin
            reg_rise_ff[i] <= 1'b0;   // [RL15]
            reg_fall_ff[i] <= 1'b0;   // [RL15]
         end else begin
            reg_rise_ff[i] <= nxt_rise;
            reg_fall_ff[i] <= nxt_fall;
         end
      end

      // Tristate flop: reset sets it, releasing the pin for reads [RL14]
      always_ff @(posedge clk_sys_i or posedge out_rst) begin
         if (out_rst) begin
            oe_n_ff[i] <= OE_N_RELEASED;  // [RL14]
         end else if (FULL_CYCLE && i < DQ_W) begin
            oe_n_ff[i] <= OE_N_RELEASED;  // [RL10]
         end else begin
            oe_n_ff[i] <= ~write_drive_i;  // [RL11]
         end
      end

      // Hold stage has no reset, so a reset mid-write keeps it [RL15]
      always_ff @(posedge xfer_clk) begin
         latch_fall_ff[i] <= reg_fall_ff[i];
      end

      // Rise word while core clock high, held fall word while low [RL12]
      assign lane_q[i] = xfer_clk ? latch_fall_ff[i] : reg_rise_ff[i];
   end

   // Pins: data and strobe with their enables [RL11]
   assign dq_o          = lane_q[DQ_W-1:0];
   assign dq_oe_n_o     = oe_n_ff[DQ_W-1:0];
   assign strobe_o      = lane_q[DQ_W];
   assign strobe_oe_n_o = oe_n_ff[DQ_W];

   // ---------------- Read results to core ----------------

   // Full mode presents the extra stage, on the fixed rising edge [RL8]
   if (FULL_CYCLE) begin : g_out_full
      assign rise_capture_out_o = reg_rise_ff[DQ_W-1:0];  // [RL8]
      assign fall_capture_out_o = reg_fall_ff[DQ_W-1:0];  // [RL8]
   end else begin : g_out_half
      assign rise_capture_out_o = sync_rise_ff;  // [RL5]
      assign fall_capture_out_o = sync_fall_ff;  // [RL5]
   end

   // ---------------- Data valid ----------------

   logic [1:0] take_dly_ff;
   logic       valid_ff;
   logic       valid_set;

   // Valid follows the word by the stages it must still pass
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         take_dly_ff <= '0;
      end else begin
         take_dly_ff <= {take_dly_ff[0], take & in_ce_i};
      end
   end

   assign valid_set = (det_ff == DET_LOCKED) &&
                      (FULL_CYCLE ? take_dly_ff[1] : take_dly_ff[0]);

   // Sticky until the next window; a word landing in the same cycle
   // keeps it set, so a tail word of the previous burst is not missed [RL22] [RL24]
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         valid_ff <= 1'b0;
      end else if (valid_set) begin
         valid_ff <= 1'b1;  // [RL22]
      end else if (win_rise) begin
         valid_ff <= 1'b0;  // [RL24]
      end
   end

   assign read_data_valid_o = valid_ff;

endmodule

//--- bench/ddr_io_path_monitor.sv
// Port-level assertion checker for the DDR I/O datapath
`timescale 1ns/100ps

module ddr_io_path_monitor
   import ddr_io_pkg::*;
#(
   parameter int DQ_W = DQ_W_DEF
) (
   // Core side
   input wire logic              clk_sys_i,
   input wire logic              rst_i,
   input wire logic              preamble_detect_i,
   input wire logic              read_window_i,
   input wire logic              in_ce_i,
   input wire logic              in_rst_i,
   input wire logic              delay_update_request_n_i,
   input wire logic [CODE_W-1:0] cal_code_left_i,
   input wire logic [DQ_W-1:0]   fall_edge_word_i,
   input wire logic [DQ_W-1:0]   rise_edge_word_i,
   input wire logic              write_drive_i,
   input wire logic              local_set_reset_i,
   // Design outputs
   input wire logic [DQ_W-1:0]   rise_capture_out_o,
   input wire logic [DQ_W-1:0]   fall_capture_out_o,
   input wire logic              read_data_valid_o,
   input wire logic              sync_clock_polarity_o,
   input wire logic [CODE_W-1:0] strobe_delay_code_o,
   input wire logic [DQ_W-1:0]   dq_o,
   input wire logic [DQ_W-1:0]   dq_oe_n_o,
   input wire logic              strobe_oe_n_o
);
   // Most checks live on the core rising edge
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   // Write lanes
   oe_idle_a: assert property (!write_drive_i |=> dq_oe_n_o == '1)
      else $error("data lanes driven while idle");
   oe_drive_a: assert property (write_drive_i && !local_set_reset_i
      ##1 !local_set_reset_i |-> !strobe_oe_n_o && dq_oe_n_o == '0)
      else $error("write lanes not driven");
   rise_word_a: assert property (@(negedge clk_sys_i)
      disable iff (rst_i || local_set_reset_i) dq_o == rise_edge_word_i)
      else $error("high phase word wrong");
   fall_word_a: assert property (!local_set_reset_i && !$past(rst_i)
      && !$past(local_set_reset_i) |-> dq_o == $past(fall_edge_word_i))
      else $error("low phase word wrong");
   // Read side
   valid_hold_a: assert property (read_data_valid_o && !read_window_i
      && !$past(read_window_i) |=> read_data_valid_o)
      else $error("valid dropped without window");
   pol_cause_a: assert property ($rose(sync_clock_polarity_o)
      |-> $past(preamble_detect_i))
      else $error("polarity moved without preamble");
   code_load_a: assert property (!delay_update_request_n_i |-> ##2
      strobe_delay_code_o == $past(cal_code_left_i, 2))
      else $error("delay code not loaded");
   code_keep_a: assert property (delay_update_request_n_i [*2]
      |-> ##2 $stable(strobe_delay_code_o))
      else $error("delay code moved without update");
   ce_hold_a: assert property (disable iff (rst_i || in_rst_i)
      !in_ce_i [*2] |=> $stable(rise_capture_out_o)
      && $stable(fall_capture_out_o))
      else $error("capture moved with enable low");
   in_clear_a: assert property (in_rst_i [*2] |->
      rise_capture_out_o == '0 && fall_capture_out_o == '0)
      else $error("capture not cleared");

   // Main scenarios reached
   cover property (sync_clock_polarity_o && read_data_valid_o);
   cover property ($rose(read_data_valid_o) && !sync_clock_polarity_o);
   cover property (write_drive_i [*4]);
endmodule

bind ddr_io_path ddr_io_path_monitor #(.DQ_W(DQ_W)) u_mon (.clk_sys_i,
   .rst_i, .preamble_detect_i, .read_window_i, .in_ce_i, .in_rst_i,
   .delay_update_request_n_i, .cal_code_left_i, .fall_edge_word_i,
   .rise_edge_word_i, .write_drive_i, .local_set_reset_i,
   .rise_capture_out_o, .fall_capture_out_o, .read_data_valid_o,
   .sync_clock_polarity_o, .strobe_delay_code_o, .dq_o, .dq_oe_n_o,
   .strobe_oe_n_o);

//--- bench/ddr_mem_model.sv
// Behavioural memory answering reads with strobe, data and preamble
`timescale 1ns/100ps

module ddr_mem_model
   import ddr_io_pkg::*;
#(
   parameter int DQ_W = DQ_W_DEF
) (
   // Read pins toward the datapath, strobe already delayed
   output logic            strobe_o,
   output logic            preamble_o,
   output logic [DQ_W-1:0] dq_o
);
   localparam realtime Q = 31.25;

   // Strobe parked low by termination until a burst
   initial begin
      strobe_o = 1'b0;
      preamble_o = 1'b0;
      dq_o = '0;
   end

   // Pairs base+2k / base+2k+1; gap pauses the strobe between pairs
   task automatic burst(input logic [7:0] base, input int n, input int gap);
      int k;
      preamble_o = 1'b1;
      #(4*Q); // Strobe held low for the preamble
      for (k = 0; k < n; k++) begin
         dq_o = DQ_W'(base + 8'(2*k));
         #(Q) strobe_o = 1'b1;
         #(Q) dq_o = DQ_W'(base + 8'(2*k+1));
         #(Q) strobe_o = 1'b0;
         #(Q) dq_o = ~dq_o; // Released data is not left at its last value
         #(gap*4*Q);
      end
      preamble_o = 1'b0;
   endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the DDR I/O datapath
`timescale 1ns/100ps

module testbench;
   import ddr_io_pkg::*;
   // Stimulus and observed nets
   logic              clk_sys_i, rst_i, read_window_i, in_ce_i, in_rst_i;
   logic              delay_update_request_n_i, write_drive_i;
   logic              local_set_reset_i, strobe_fall_i, strobe_rise_i;
   logic [CODE_W-1:0] cal_code_left_i, cal_code_right_i, strobe_delay_code_o;
   logic [7:0]        fall_edge_word_i, rise_edge_word_i, rise_capture_out_o;
   logic [7:0]        fall_capture_out_o, dq_i, dq_o, dq_oe_n_o;
   logic              strobe_i, preamble_detect_i, read_data_valid_o;
   logic              sync_clock_polarity_o, strobe_o, strobe_oe_n_o;
   logic              write_transfer_clock_o;
   int                mismatches, compares;

   ddr_io_path u_dut (.clk_sys_i, .rst_i, .strobe_i, .preamble_detect_i,
      .dq_i, .read_window_i, .in_ce_i, .in_rst_i, .delay_update_request_n_i,
      .cal_code_left_i, .cal_code_right_i, .fall_edge_word_i,
      .rise_edge_word_i, .strobe_fall_i, .strobe_rise_i, .write_drive_i,
      .local_set_reset_i, .rise_capture_out_o, .fall_capture_out_o,
      .read_data_valid_o, .sync_clock_polarity_o, .strobe_delay_code_o,
      .dq_o, .dq_oe_n_o, .strobe_o, .strobe_oe_n_o, .write_transfer_clock_o);
   ddr_mem_model u_mem (.strobe_o(strobe_i), .preamble_o(preamble_detect_i),
      .dq_o(dq_i));

   // Core clock, 100 ns
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // One-cycle window pulse, raised and dropped on falling core edges
   task automatic pulse_window;
      @(negedge clk_sys_i);
      read_window_i <= 1'b1;
      @(negedge clk_sys_i);
      read_window_i <= 1'b0;
   endtask

   // Phase offset after a falling edge decides the clock level at preamble
   task automatic test_read(input logic pol, input realtime ph);
      logic [7:0] b;
      b = pol ? 8'h40 : 8'h10;
      pulse_window();
      #(ph);
      u_mem.burst(b, 4, 3);
      repeat (8) @(negedge clk_sys_i);
      chk(sync_clock_polarity_o, pol);
      chk(rise_capture_out_o, b + 8'h06);
      chk(fall_capture_out_o, b + 8'h07);
      chk(read_data_valid_o, 1'b1);
      pulse_window();
      repeat (2) @(negedge clk_sys_i);
      chk(read_data_valid_o, 1'b0);
      $display("test_read done");
   endtask

   // New window while the previous burst is still trailing
   task automatic test_overlap;
      #20; // Keep the preamble rise off the core clock edges
      fork
         u_mem.burst(8'h80, 4, 3);
         begin
            #1700;
            pulse_window();
         end
      join
      repeat (3) @(negedge clk_sys_i);
      #20;
      u_mem.burst(8'ha0, 4, 3);
      repeat (8) @(negedge clk_sys_i);
      chk(rise_capture_out_o, 8'ha6);
      chk(fall_capture_out_o, 8'ha7);
      chk(read_data_valid_o, 1'b1);
      $display("test_overlap done");
   endtask

   // Enable low freezes capture, then input reset clears it
   task automatic test_ce_rst;
      in_ce_i <= 1'b0;
      pulse_window();
      #20;
      u_mem.burst(8'hc0, 2, 3);
      repeat (8) @(negedge clk_sys_i);
      chk(rise_capture_out_o, 8'ha6);
      chk(fall_capture_out_o, 8'ha7);
      in_ce_i <= 1'b1;
      in_rst_i <= 1'b1;
      repeat (2) @(negedge clk_sys_i);
      chk(rise_capture_out_o, 8'h00);
      chk(fall_capture_out_o, 8'h00);
      in_rst_i <= 1'b0;
      $display("test_ce_rst done");
   endtask

   // Delay code follows the left loop only while update is held low
   task automatic test_code;
      cal_code_left_i <= 6'h2a;
      cal_code_right_i <= 6'h15;
      delay_update_request_n_i <= 1'b0;
      repeat (3) @(negedge clk_sys_i);
      delay_update_request_n_i <= 1'b1;
      cal_code_left_i <= 6'h0c;
      repeat (3) @(negedge clk_sys_i);
      chk(strobe_delay_code_o, 6'h2a);
      $display("test_code done");
   endtask

   // Back-to-back words, then output reset in mid-write
   task automatic test_write;
      logic [7:0] f;
      for (int k = 0; k < 4; k++) begin
         @(negedge clk_sys_i);
         fall_edge_word_i <= 8'h31 + 8'(k);
         rise_edge_word_i <= 8'hc2 + 8'(k);
         strobe_rise_i <= 1'b1;
         write_drive_i <= 1'b1;
         if (k > 0) #10 chk(dq_o, f);
         f = 8'h31 + 8'(k);
         @(posedge clk_sys_i);
         #10 chk(dq_o, 8'hc2 + 8'(k));
         chk(write_transfer_clock_o, 1'b1);
         chk(dq_oe_n_o, 8'h00);
         chk({strobe_o, strobe_oe_n_o}, 2'h2);
      end
      @(negedge clk_sys_i);
      local_set_reset_i <= 1'b1;
      #10 chk(dq_o, f);
      chk({dq_oe_n_o, strobe_oe_n_o}, 9'h1ff);
      @(posedge clk_sys_i);
      #10 chk(dq_o, 8'h00);
      @(negedge clk_sys_i);
      local_set_reset_i <= 1'b0;
      write_drive_i <= 1'b0;
      $display("test_write done");
   endtask

   // Main sequence
   initial begin
      rst_i = 1'b1;
      {read_window_i, in_rst_i, write_drive_i, local_set_reset_i} = 4'h0;
      {in_ce_i, delay_update_request_n_i} = 2'h3;
      {strobe_fall_i, strobe_rise_i} = 2'h0;
      {cal_code_left_i, cal_code_right_i} = 12'h000;
      {fall_edge_word_i, rise_edge_word_i} = 16'h0000;
      mismatches = 0;
      compares = 0;
      repeat (16) @(negedge clk_sys_i);
      rst_i <= 1'b0;
      test_code();
      test_write();
      test_read(1'b0, 20);
      test_read(1'b1, 70);
      test_overlap();
      test_ce_rst();
      stop_test();
   end

   // Hang guard, well beyond the whole sequence
   initial begin
      #600000;
      mismatches++;
      stop_test();
   end
endmodule
